// >>> logic/expander_irq_defs.vh
// Purpose: constants for the expander reset and change-interrupt block
// Assumes: 16 port pins split into two 8-bit ports
// Notes:   mask bits come out of reset set, capture enables cleared
`ifndef EXPANDER_IRQ_DEFS_VH
`define EXPANDER_IRQ_DEFS_VH

// ****************************************
// port geometry
// ****************************************
`define PORT_WIDTH        8
`define PORT_COUNT        2

// ****************************************
// reset values
// ****************************************
`define MASK_RESET        8'hff
`define CAPTURE_RESET     8'h00
`define INPUT_RESET       8'h00
`define DIR_RESET         8'hff

// ****************************************
// synchroniser depth
// ****************************************
`define SYNC_STAGES       2

`endif

// >>> logic/port_event.v
// Purpose: change detection and source flags for one 8-bit port
// Assumes: pin levels and scl already synchronised into clk_i
// Notes:   one instance per port
`timescale 1ns/1ps
`default_nettype none
`include "expander_irq_defs.vh"

module port_event #(
   parameter WIDTH = `PORT_WIDTH
) (
   // clock and reset
   input  wire             clk_i,
   input  wire             rst_n_i,
   // pin state and configuration
   input  wire [WIDTH-1:0] pin_i,
   input  wire [WIDTH-1:0] is_input_i,
   input  wire [WIDTH-1:0] mask_i,
   input  wire [WIDTH-1:0] capture_en_i,
   // read acknowledge of this port
   input  wire             read_ack_i,
   // results
   output reg  [WIDTH-1:0] input_value_o,
   output reg  [WIDTH-1:0] source_o,
   output reg              pending_o
);

   reg  [WIDTH-1:0] ref_q;
   reg  [WIDTH-1:0] ref_d;
   reg  [WIDTH-1:0] event_q;
   reg  [WIDTH-1:0] event_d;
   reg  [WIDTH-1:0] latch_q;
   reg  [WIDTH-1:0] latch_d;
   reg  [WIDTH-1:0] src_d;
   integer          i;

   // ****************************************
   // per-pin event tracking
   // ****************************************
   // ref holds the last value the host read; differences raise events
   always @* begin
      ref_d   = ref_q;
      event_d = event_q;
      latch_d = latch_q;
      for (i = 0; i < WIDTH; i = i + 1) begin
         if (!is_input_i[i]) begin
            event_d[i] = 1'b0;
         end else if (capture_en_i[i]) begin
            // hold the changed level, not the live one
            if (!event_q[i] && pin_i[i] != ref_q[i]) begin
               event_d[i] = 1'b1;
               latch_d[i] = pin_i[i];
            end
            if (read_ack_i && event_q[i]) begin
               event_d[i] = 1'b0;
               ref_d[i]   = latch_q[i];
            end
         end else begin
            // return to the original level clears the event
            event_d[i] = (pin_i[i] != ref_q[i]);
            latch_d[i] = pin_i[i];
            if (read_ack_i) begin
               ref_d[i]   = pin_i[i];
               event_d[i] = 1'b0;
            end
         end
      end
      src_d = event_d & ~mask_i;
   end

   // ****************************************
   // state registers
   // ****************************************
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ref_q         <= `INPUT_RESET;
         event_q       <= {WIDTH{1'b0}};
         latch_q       <= `INPUT_RESET;
         input_value_o <= `INPUT_RESET;
         source_o      <= {WIDTH{1'b0}};
         pending_o     <= 1'b0;
      end else begin
         ref_q         <= ref_d;
         event_q       <= event_d;
         latch_q       <= latch_d;
         // latched pins show the held level to the host
         input_value_o <= (capture_en_i & latch_d) | (~capture_en_i & pin_i);
         source_o      <= src_d;
         pending_o     <= |src_d;
      end
   end

endmodule
`default_nettype wire

// >>> logic/expander_irq.v
// Purpose: reset input and open-drain change interrupt of a 16-bit expander
// Assumes: clk_i at 20 MHz; pins and scl asynchronous; no register bus
// Notes:   configuration arrives on plain ports from the register logic
`timescale 1ns/1ps
`default_nettype none
`include "expander_irq_defs.vh"

module expander_irq #(
   parameter W = `PORT_WIDTH
) (
   // clock and power-on reset
   input  wire           clk_i,
   input  wire           rst_n_i,
   // external reset pin, active low
   input  wire           reset_pin_n_i,
   // port pins
   input  wire [W-1:0]   port0_pin_i,
   input  wire [W-1:0]   port1_pin_i,
   // configuration: 1 = input
   input  wire [W-1:0]   port0_dir_i,
   input  wire [W-1:0]   port1_dir_i,
   // event masks from host writes
   input  wire [W-1:0]   port0_event_mask_bit_i,
   input  wire [W-1:0]   port1_event_mask_bit_i,
   input  wire           mask_wr_i,
   // capture enables
   input  wire [W-1:0]   port0_capture_enable_bit_i,
   input  wire [W-1:0]   port1_capture_enable_bit_i,
   input  wire           capture_wr_i,
   // i2c read of input port: scl and ack-phase markers
   input  wire           scl_i,
   input  wire           read_ack_phase_i,
   input  wire           read_port_sel_i,
   // status and interrupt
   output reg  [W-1:0]   port0_value_o,
   output reg  [W-1:0]   port1_value_o,
   output reg  [W-1:0]   port0_event_source_flag_o,
   output reg  [W-1:0]   port1_event_source_flag_o,
   output reg  [W-1:0]   port0_event_mask_o,
   output reg  [W-1:0]   port1_event_mask_o,
   output reg            access_ok_o,
   output reg            irq_n_o,
   output reg            irq_n_oe_o
);

   // ****************************************
   // reset release and pin synchronisers
   // ****************************************
   reg  [1:0]   rst_sync_q;
   wire         rst_n;
   reg  [2*W+4-1:0] s1_q;
   reg  [2*W+4-1:0] s2_q;
   reg          scl_prev_q;

   // power-on reset released through two flops
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // two flops on every asynchronous input before use
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         // scl resets to its idle high level so no false edge follows
         s1_q <= {1'b0, 1'b1, {(2*W+2){1'b0}}};
         s2_q <= {1'b0, 1'b1, {(2*W+2){1'b0}}};
      end else begin
         s1_q <= {reset_pin_n_i, scl_i, read_ack_phase_i, read_port_sel_i,
                  port1_pin_i, port0_pin_i};
         s2_q <= s1_q;
      end
   end

   wire         pin_rst_n = s2_q[2*W+3];
   wire         scl_s     = s2_q[2*W+2];
   wire         ack_s     = s2_q[2*W+1];
   wire         sel_s     = s2_q[2*W];
   wire [W-1:0] p0_s      = s2_q[W-1:0];
   wire [W-1:0] p1_s      = s2_q[2*W-1:W];

   // reset pin clears the block without a supply cycle
   reg  [1:0]   blk_rst_q;
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         blk_rst_q <= 2'b00;
      end else begin
         blk_rst_q <= {blk_rst_q[0], pin_rst_n};
      end
   end
   wire core_rst_n = blk_rst_q[1] & rst_n;
   // hazard: this is a synchronous source used as an async clear;
   // it is the AND of two flops, blk_rst_q[1] and rst_n, so it is glitch free

   // ****************************************
   // scl edge and read acknowledge
   // ****************************************
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         scl_prev_q <= 1'b1;
      end else begin
         scl_prev_q <= scl_s;
      end
   end
   // clear fires on scl rise in the ack/nack bit of a port read
   wire scl_rise = scl_s & ~scl_prev_q;
   wire rd_ack   = scl_rise & ack_s & pin_rst_n;
   wire rd_ack0  = rd_ack & ~sel_s;
   wire rd_ack1  = rd_ack & sel_s;

   // ****************************************
   // configuration registers
   // ****************************************
   reg  [W-1:0] cap0_q;
   reg  [W-1:0] cap1_q;
   always @(posedge clk_i or negedge core_rst_n) begin
      if (!core_rst_n) begin
         port0_event_mask_o <= `MASK_RESET;
         port1_event_mask_o <= `MASK_RESET;
         cap0_q             <= `CAPTURE_RESET;
         cap1_q             <= `CAPTURE_RESET;
      end else begin
         // writes ignored while reset pin is low
         if (mask_wr_i && pin_rst_n) begin
            port0_event_mask_o <= port0_event_mask_bit_i;
            port1_event_mask_o <= port1_event_mask_bit_i;
         end
         if (capture_wr_i && pin_rst_n) begin
            cap0_q <= port0_capture_enable_bit_i;
            cap1_q <= port1_capture_enable_bit_i;
         end
      end
   end

   // ****************************************
   // per-port event logic
   // ****************************************
   wire [W-1:0] val0;
   wire [W-1:0] val1;
   wire [W-1:0] src0;
   wire [W-1:0] src1;
   wire         pend0;
   wire         pend1;

   port_event #(.WIDTH(W)) u_port0 (
      .clk_i         (clk_i),
      .rst_n_i       (core_rst_n),
      .pin_i         (p0_s),
      .is_input_i    (port0_dir_i),
      .mask_i        (port0_event_mask_o),
      .capture_en_i  (cap0_q),
      .read_ack_i    (rd_ack0),
      .input_value_o (val0),
      .source_o      (src0),
      .pending_o     (pend0)
   );

   port_event #(.WIDTH(W)) u_port1 (
      .clk_i         (clk_i),
      .rst_n_i       (core_rst_n),
      .pin_i         (p1_s),
      .is_input_i    (port1_dir_i),
      .mask_i        (port1_event_mask_o),
      .capture_en_i  (cap1_q),
      .read_ack_i    (rd_ack1),
      .input_value_o (val1),
      .source_o      (src1),
      .pending_o     (pend1)
   );

   // ****************************************
   // outputs from flops
   // ****************************************
   // open drain: drive low (oe low) only while an event is pending
   always @(posedge clk_i or negedge core_rst_n) begin
      if (!core_rst_n) begin
         port0_value_o             <= `INPUT_RESET;
         port1_value_o             <= `INPUT_RESET;
         port0_event_source_flag_o <= {W{1'b0}};
         port1_event_source_flag_o <= {W{1'b0}};
         access_ok_o               <= 1'b0;
         irq_n_o                   <= 1'b0;
         irq_n_oe_o                <= 1'b1;
      end else begin
         port0_value_o             <= val0;
         port1_value_o             <= val1;
         port0_event_source_flag_o <= src0;
         port1_event_source_flag_o <= src1;
         access_ok_o               <= pin_rst_n;
         irq_n_o                   <= 1'b0;
         irq_n_oe_o                <= ~(pend0 | pend1);
      end
   end

endmodule
`default_nettype wire

// >>> dv/expander_irq_sva.sv
// Purpose: port assertions for the expander change-interrupt block
// Assumes: single clock domain clk_i, power-on reset rst_n_i
// Notes:   bound to every expander_irq instance
`timescale 1ns/1ps
`default_nettype none
module expander_irq_sva #(parameter W = 8) (
   input wire         clk_i, rst_n_i, reset_pin_n_i, mask_wr_i,
   input wire         capture_wr_i, scl_i, read_ack_phase_i, read_port_sel_i,
   input wire [W-1:0] port0_pin_i, port1_pin_i, port0_dir_i, port1_dir_i,
   input wire [W-1:0] port0_event_mask_bit_i, port1_event_mask_bit_i,
   input wire [W-1:0] port0_capture_enable_bit_i, port1_capture_enable_bit_i,
   input wire [W-1:0] port0_value_o, port1_value_o,
   input wire [W-1:0] port0_event_source_flag_o, port1_event_source_flag_o,
   input wire [W-1:0] port0_event_mask_o, port1_event_mask_o,
   input wire         access_ok_o, irq_n_o, irq_n_oe_o);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // line released and config frozen: port0 pins sit at their reference
   sequence settled0;
      (irq_n_oe_o && access_ok_o && !mask_wr_i && !capture_wr_i
       && $stable(port0_pin_i) && $stable(port0_dir_i))[*4];
   endsequence
   sequence edge0;
      |((port0_pin_i ^ $past(port0_pin_i)) & port0_dir_i
        & ~port0_event_mask_o);
   endsequence
   sequence held0;
      ($stable(port0_pin_i) && $stable(port0_dir_i) && !read_ack_phase_i
       && !mask_wr_i && !capture_wr_i && access_ok_o)[*4];
   endsequence
   sequence read0;
      $rose(scl_i) && read_ack_phase_i && !read_port_sel_i;
   endsequence
   sequence dir_steady;
      ($stable(port0_dir_i) && $stable(port1_dir_i))[*6];
   endsequence
   a_irq_data_low: assert property (irq_n_o == 1'b0)
      else $error("open-drain data not low");
   a_irq_or_flags: assert property (irq_n_oe_o ==
      !(|port0_event_source_flag_o || |port1_event_source_flag_o))
      else $error("interrupt line disagrees with flags");
   // flags trail the mask by two flops: compare with the mask they saw
   a_flags_masked: assert property (((port0_event_source_flag_o &
      $past(port0_event_mask_o, 2)) | (port1_event_source_flag_o &
      $past(port1_event_mask_o, 2))) == '0)
      else $error("masked pin shows a flag");
   a_output_quiet: assert property (dir_steady |->
      ((port0_event_source_flag_o & ~port0_dir_i)
      | (port1_event_source_flag_o & ~port1_dir_i)) == '0)
      else $error("output pin shows a flag");
   // pin sync and block reset flops take four edges before the clear
   a_reset_defaults: assert property ((!reset_pin_n_i)[*5] |->
      port0_event_mask_o == {W{1'b1}} && port1_event_mask_o == {W{1'b1}}
      && port0_event_source_flag_o == '0 && port1_event_source_flag_o == '0
      && port0_value_o == '0 && irq_n_oe_o)
      else $error("state not at defaults in reset");
   a_mask_load: assert property (
      mask_wr_i && reset_pin_n_i && access_ok_o
      |=> port0_event_mask_o == $past(port0_event_mask_bit_i)
      && port1_event_mask_o == $past(port1_event_mask_bit_i))
      else $error("mask write not taken");
   a_access_gate: assert property (
      !reset_pin_n_i |-> ##[0:4] !access_ok_o)
      else $error("access allowed in reset");
   a_edge_raise: assert property (settled0 ##1 edge0 ##1 held0
      |-> !irq_n_oe_o) else $error("pin edge raised no interrupt");
   a_read_clear: assert property (read0 |-> ##[1:6]
      port0_event_source_flag_o == '0) else $error("read did not clear");
endmodule
bind expander_irq expander_irq_sva #(.W(W)) u_sva (.*);
`default_nettype wire

// >>> dv/i2c_host_model.sv
// Purpose: far-side controller: reset pin and read acknowledge bits
// Assumes: scl at 400 ns period, idle high between frames
// Notes:   select line inverted after each frame, never left stale
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model #(parameter int TW_NS = 1000) (
   output logic reset_pin_n_o,
   output logic scl_o,
   output logic ack_phase_o,
   output logic port_sel_o);
   initial begin
      reset_pin_n_o = 1'b1;
      scl_o = 1'b1;
      ack_phase_o = 1'b0;
      port_sel_o = 1'b0;
   end
   // pulse no shorter than the minimum width
   task automatic pulse_reset();
      reset_pin_n_o = 1'b0;
      #(TW_NS);
      reset_pin_n_o = 1'b1;
   endtask
   // eight data bits then the ack bit of an input-port read
   task automatic read_port(input logic sel);
      port_sel_o = sel;
      for (int i = 0; i < 9; i++) begin
         scl_o = 1'b0;
         ack_phase_o = (i == 8);
         #200;
         scl_o = 1'b1;
         #200;
      end
      scl_o = 1'b0;
      #100;
      ack_phase_o = 1'b0;
      port_sel_o = ~sel;
      #100;
      scl_o = 1'b1;
   endtask
endmodule
`default_nettype wire

// >>> dv/expander_irq_tb_top.sv
// Purpose: self-checking bench for the expander change interrupt
// Assumes: unlatched reference model kept in ref_q, both ports as 16 bits
// Notes:   random pins, directions and masks from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module expander_irq_tb_top;
   logic        clk_i = 1'b0, rst_n_i = 1'b0, mask_wr_i = 1'b0;
   logic        capture_wr_i = 1'b0;
   logic [15:0] pins = '0, dir = '1, mask = '1, capt = '0, ref_q = '0;
   wire         rp_n, scl, ackp, psel, access_ok, irq_n, irq_oe;
   wire  [15:0] value, flags, mask_o;
   int          n_fail = 0, n_checks = 0;
   always #25 clk_i = ~clk_i;
   i2c_host_model HOST (.reset_pin_n_o(rp_n), .scl_o(scl),
      .ack_phase_o(ackp), .port_sel_o(psel));
   expander_irq DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .reset_pin_n_i(rp_n),
      .port0_pin_i(pins[7:0]), .port1_pin_i(pins[15:8]),
      .port0_dir_i(dir[7:0]), .port1_dir_i(dir[15:8]),
      .port0_event_mask_bit_i(mask[7:0]), .port1_event_mask_bit_i(mask[15:8]),
      .mask_wr_i(mask_wr_i), .port0_capture_enable_bit_i(capt[7:0]),
      .port1_capture_enable_bit_i(capt[15:8]), .capture_wr_i(capture_wr_i),
      .scl_i(scl), .read_ack_phase_i(ackp), .read_port_sel_i(psel),
      .port0_value_o(value[7:0]), .port1_value_o(value[15:8]),
      .port0_event_source_flag_o(flags[7:0]),
      .port1_event_source_flag_o(flags[15:8]),
      .port0_event_mask_o(mask_o[7:0]), .port1_event_mask_o(mask_o[15:8]),
      .access_ok_o(access_ok), .irq_n_o(irq_n), .irq_n_oe_o(irq_oe));
   function automatic logic [15:0] exp_flags(input logic [15:0] p, r, d, m);
      return (p ^ r) & d & ~m;
   endfunction
   task automatic chk(input logic [15:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // four-edge latency plus margin
   task automatic settle();
      repeat (8) @(negedge clk_i);
   endtask
   task automatic wr(input logic cap, input logic [15:0] v);
      @(negedge clk_i);
      if (cap) begin
         capt = v;
         capture_wr_i = 1'b1;
      end else begin
         mask = v;
         mask_wr_i = 1'b1;
      end
      @(negedge clk_i);
      mask_wr_i = 1'b0;
      capture_wr_i = 1'b0;
   endtask
   // read ack makes the live level the new reference of that port
   // output pins of the read port keep their old reference
   task automatic rd(input logic sel);
      logic [15:0] upd;
      HOST.read_port(sel);
      upd = dir & (sel ? 16'hff00 : 16'h00ff);
      ref_q = (ref_q & ~upd) | (pins & upd);
      settle();
   endtask
   task automatic chk_state();
      chk(flags, exp_flags(pins, ref_q, dir, mask));
      chk({15'h0, irq_oe}, {15'h0, exp_flags(pins, ref_q, dir, mask) == 0});
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #3_000_000;
      n_fail++;
      $display("BAD %0t watchdog expired", $time);
      tally_and_finish();
   end
   initial begin
      void'($urandom(32'h356f));
      repeat (20) @(negedge clk_i);
      rst_n_i = 1'b1;
      pins = $urandom;
      settle();
      chk(mask_o, 16'hffff);
      chk({15'h0, irq_oe}, 16'h0001);
      chk({15'h0, irq_n}, 16'h0000);
      $display("test defaults done");
      for (int i = 0; i < 12; i++) begin
         dir = (i == 0) ? 16'hffff : 16'($urandom);
         wr(0, (i == 0) ? 16'h0000 : 16'($urandom));
         settle();
         chk_state();
         chk(mask_o, mask);
         pins = $urandom;
         settle();
         chk_state();
         chk(value & dir, pins & dir);
         rd(i[0]);
         chk_state();
         pins = ref_q;
         settle();
         chk_state();
      end
      $display("test random done");
      dir = '1;
      pins = '0;
      wr(0, 16'h0000);
      rd(0);
      rd(1);
      wr(1, 16'h0001);
      pins[0] = 1'b1;
      settle();
      chk(flags, 16'h0001);
      pins[0] = 1'b0;
      settle();
      chk(flags, 16'h0001);
      chk({15'h0, value[0]}, 16'h0001);
      rd(0);
      // pin now differs from the held level just read: a fresh event
      chk(flags, 16'h0001);
      chk({15'h0, value[0]}, 16'h0000);
      rd(0);
      chk(flags, 16'h0000);
      wr(1, 16'h0000);
      $display("test capture done");
      pins = $urandom;
      fork
         HOST.pulse_reset();
         begin
            repeat (8) @(negedge clk_i);
            chk({15'h0, access_ok}, 16'h0000);
            chk({flags[15:1], irq_oe}, 16'h0001);
            wr(0, 16'h0000);
         end
      join
      settle();
      chk(mask_o, 16'hffff);
      chk({15'h0, access_ok}, 16'h0001);
      mask = '1;
      ref_q = '0;
      wr(0, 16'h0000);
      settle();
      chk_state();
      $display("test reset pin done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
